// ==== design/rpp_port.sv ====
// Point-to-point serial port on a half-duplex differential line
// Operation
// - After overall reset the interface is off: no send, no receive.
// - Point-to-point operation only when the interface function selects it.
// - Host bytes go to a 2x1024 byte send FIFO, sent in order.
// - Received bytes go to a 2x1024 byte receive FIFO, read in order.
// - Delimited mode adds its start/end characters to outgoing payload automatically; other modes add no framing.
// - Procedure, USS, Modbus need partner acknowledge; char and delimited do not.
// - Each repeated send request returns the current partner acknowledge state.
// - Five modes: plain, delimited, procedure, USS, Modbus.
// - Two-wire half duplex: never transmit and receive together.
// - Bit rates up to 115.2 kilobaud.
`timescale 1ns/1ps
`default_nettype none

`include "rpp_map.svh"

module rpp_port #(
    parameter int BUF_BYTES  = `RPP_BUF_BYTES,
    parameter int FIFO_DEPTH = `RPP_FIFO_DEPTH
) (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        serial_configure_request,
    input  wire logic        interface_function_setting,
    input  wire logic [2:0]  cfg_mode,
    input  wire logic [15:0] cfg_bit_div,
    input  wire logic [7:0]  cfg_start_char,
    input  wire logic [7:0]  cfg_end_char,
    input  wire logic        serial_send_request,
    input  wire logic [7:0]  send_data,
    input  wire logic        send_last,
    output logic [7:0]       request_return_status,
    input  wire logic        serial_receive_request,
    output logic [7:0]       receive_data,
    output logic             receive_valid,
    input  wire logic        line_rx,
    output logic             line_tx,
    output logic             line_tx_oe
);
    localparam int PW = $clog2(BUF_BYTES);

    initial begin
        if (BUF_BYTES < 4 || (BUF_BYTES & (BUF_BYTES - 1)) != 0)
            $error("rpp_port: BUF_BYTES must be a power of two");
    end

    //--------------------------------------------------------------
    // State
    //--------------------------------------------------------------
    typedef struct packed {
        logic               enabled;
        rpp_pkg::rpp_mode_t mode;
        logic [15:0]        div;
        logic [7:0]         start_ch;
        logic [7:0]         end_ch;
        logic [PW:0]        tw;
        logic [PW:0]        tr;
        logic [PW:0]        rw;
        logic [PW:0]        rr;
        logic               last_pend;
        rpp_pkg::rpp_tx_t   txs;
        logic [9:0]         tsh;
        logic [3:0]         tbits;
        logic [15:0]        tcnt;
        logic               tmark;
        logic               rbusy;
        logic [15:0]        rcnt;
        logic [3:0]         rbits;
        logic [7:0]         rsh;
        logic               ack_wait;
        logic               ack_ok;
        logic               ack_neg;
        logic               sent;
        logic               full_hit;
        logic [7:0]         status;
        logic [7:0]         rdata;
        logic               rvalid;
        logic [1:0]         rx_sync;
        logic               txo;
        logic               oe;
    } rpp_st_t;

    rpp_st_t    s_q;
    rpp_st_t    s_d;
    logic [7:0] tx_mem [BUF_BYTES];
    logic [7:0] rx_mem [BUF_BYTES];
    logic [8:0] f_in;
    logic       f_in_valid;
    logic       f_in_ready;
    logic [8:0] f_out;
    logic       f_out_valid;
    logic       f_out_ready;
    logic       tx_full;
    logic       tx_empty;
    logic       rx_full;
    logic       rx_empty;
    logic       tx_push;
    logic       rx_push;
    logic       need_ack;
    logic       rx_bit;

    function automatic logic [9:0] frame_byte(input logic [7:0] b);
        frame_byte = {1'b1, b, 1'b0};
    endfunction : frame_byte

    function automatic logic acked_mode(input rpp_pkg::rpp_mode_t m);
        acked_mode = (m == rpp_pkg::RPP_MODE_PROC) ||
                     (m == rpp_pkg::RPP_MODE_USS)  ||
                     (m == rpp_pkg::RPP_MODE_MBUS);
    endfunction : acked_mode

    //--------------------------------------------------------------
    // Host side staging FIFO
    //--------------------------------------------------------------
    assign tx_full    = (s_q.tw - s_q.tr) == (PW + 1)'(BUF_BYTES);
    assign tx_empty   = s_q.tw == s_q.tr;
    assign rx_full    = (s_q.rw - s_q.rr) == (PW + 1)'(BUF_BYTES);
    assign rx_empty   = s_q.rw == s_q.rr;
    assign f_in       = {send_last, send_data};
    assign f_in_valid = serial_send_request && s_q.enabled;
    assign f_out_ready = !tx_full;
    assign tx_push    = f_out_valid && f_out_ready;
    assign need_ack   = acked_mode(s_q.mode);
    assign rx_bit     = s_q.rx_sync[1];

    rpp_fifo #(
        .WIDTH (9),
        .DEPTH (FIFO_DEPTH)
    ) u_stage (
        .clock     (clock),
        .rst       (rst),
        .in_data   (f_in),
        .in_valid  (f_in_valid),
        .in_ready  (f_in_ready),
        .out_data  (f_out),
        .out_valid (f_out_valid),
        .out_ready (f_out_ready)
    );

    assign rx_push = s_q.rbusy && s_q.rcnt == 16'h0000 &&
                     s_q.rbits == 4'h9 && rx_bit && !rx_full;

    //--------------------------------------------------------------
    // Next state
    //--------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.rx_sync = {s_q.rx_sync[0], line_rx};
        s_d.rvalid  = 1'b0;
        if (serial_configure_request) begin
            s_d.enabled  = interface_function_setting;
            s_d.mode     = rpp_pkg::rpp_mode_t'(cfg_mode);
            s_d.div      = (cfg_bit_div < 16'(`RPP_MIN_DIV)) ?
                           16'(`RPP_MIN_DIV) : cfg_bit_div;
            s_d.start_ch = cfg_start_char;
            s_d.end_ch   = cfg_end_char;
            s_d.ack_wait = 1'b0;
            s_d.ack_ok   = 1'b0;
            s_d.ack_neg  = 1'b0;
        end
        if (tx_push) begin
            s_d.tw = s_q.tw + 1'b1;
            if (f_out[8])
                s_d.last_pend = 1'b1;
        end
        if (serial_send_request) begin
            s_d.full_hit = !f_in_ready;
            s_d.sent     = 1'b0;
        end
        // Transmitter
        if (s_q.tcnt != 16'h0000)
            s_d.tcnt = s_q.tcnt - 16'h0001;
        case (s_q.txs)
            rpp_pkg::RPP_TX_IDLE: begin
                s_d.oe = 1'b0;
                s_d.txo = 1'b1;
                if (s_q.enabled && !tx_empty && !s_q.rbusy) begin
                    s_d.oe = 1'b1;
                    s_d.txs = (s_q.mode == rpp_pkg::RPP_MODE_DELIM &&
                               s_q.start_ch != `RPP_CHAR_NONE) ?
                              rpp_pkg::RPP_TX_START : rpp_pkg::RPP_TX_DATA;
                end
            end
            rpp_pkg::RPP_TX_START: begin
                s_d.tsh   = frame_byte(s_q.start_ch);
                s_d.tbits = 4'hA;
                s_d.tcnt  = 16'h0000;
                s_d.tmark = 1'b0;
                s_d.txs   = rpp_pkg::RPP_TX_BIT;
            end
            rpp_pkg::RPP_TX_DATA: begin
                if (tx_empty) begin
                    s_d.txs = rpp_pkg::RPP_TX_IDLE;
                end else begin
                    s_d.tsh   = frame_byte(tx_mem[s_q.tr[PW-1:0]]);
                    s_d.tr    = s_q.tr + 1'b1;
                    s_d.tbits = 4'hA;
                    s_d.tcnt  = 16'h0000;
                    s_d.tmark = (s_q.tr + 1'b1) == s_q.tw && s_q.last_pend;
                    s_d.txs   = rpp_pkg::RPP_TX_BIT;
                end
            end
            rpp_pkg::RPP_TX_END: begin
                s_d.tsh   = frame_byte(s_q.end_ch);
                s_d.tbits = 4'hA;
                s_d.tcnt  = 16'h0000;
                s_d.tmark = 1'b1;
                s_d.mode  = s_q.mode;
                s_d.txs   = rpp_pkg::RPP_TX_BIT;
                s_d.last_pend = 1'b0;
            end
            rpp_pkg::RPP_TX_BIT: begin
                if (s_q.tcnt == 16'h0000) begin
                    if (s_q.tbits == 4'h0) begin
                        if (s_q.tmark && s_q.last_pend &&
                            s_q.mode == rpp_pkg::RPP_MODE_DELIM &&
                            s_q.end_ch != `RPP_CHAR_NONE) begin
                            s_d.txs = rpp_pkg::RPP_TX_END;
                        end else begin
                            if (s_q.tmark) begin
                                s_d.last_pend = 1'b0;
                                s_d.sent      = 1'b1;
                                s_d.ack_wait  = need_ack;
                                s_d.ack_ok    = 1'b0;
                                s_d.ack_neg   = 1'b0;
                            end
                            s_d.txs = tx_empty ? rpp_pkg::RPP_TX_IDLE :
                                                 rpp_pkg::RPP_TX_DATA;
                        end
                    end else begin
                        s_d.txo   = s_q.tsh[0];
                        s_d.tsh   = {1'b1, s_q.tsh[9:1]};
                        s_d.tbits = s_q.tbits - 4'h1;
                        s_d.tcnt  = s_q.div - 16'h0001;
                    end
                end
            end
            default: s_d.txs = rpp_pkg::RPP_TX_IDLE;
        endcase
        // Receiver, idle while transmitting
        if (!s_q.enabled || s_q.oe) begin
            s_d.rbusy = 1'b0;
        end else if (!s_q.rbusy) begin
            if (!rx_bit) begin
                s_d.rbusy = 1'b1;
                s_d.rcnt  = {1'b0, s_q.div[15:1]};
                s_d.rbits = 4'h0;
            end
        end else if (s_q.rcnt != 16'h0000) begin
            s_d.rcnt = s_q.rcnt - 16'h0001;
        end else begin
            s_d.rcnt = s_q.div - 16'h0001;
            if (s_q.rbits == 4'h0 && rx_bit)
                s_d.rbusy = 1'b0;
            else if (s_q.rbits == 4'h9)
                s_d.rbusy = 1'b0;
            else begin
                s_d.rbits = s_q.rbits + 4'h1;
                if (s_q.rbits != 4'h0)
                    s_d.rsh = {rx_bit, s_q.rsh[7:1]};
            end
        end
        if (rx_push) begin
            s_d.rw = s_q.rw + 1'b1;
            if (s_q.ack_wait) begin
                s_d.ack_wait = 1'b0;
                s_d.ack_neg  = s_q.rsh == `RPP_NAK_CHAR;
                s_d.ack_ok   = s_q.rsh != `RPP_NAK_CHAR;
            end
        end
        if (serial_receive_request && !rx_empty) begin
            s_d.rdata  = rx_mem[s_q.rr[PW-1:0]];
            s_d.rvalid = 1'b1;
            s_d.rr     = s_q.rr + 1'b1;
        end
        s_d.status = '0;
        s_d.status[`RPP_ST_SENT_BIT]     = s_d.sent;
        s_d.status[`RPP_ST_FULL_BIT]     = s_d.full_hit;
        s_d.status[`RPP_ST_ACKWAIT_BIT]  = s_d.ack_wait;
        s_d.status[`RPP_ST_ACKOK_BIT]    = s_d.ack_ok;
        s_d.status[`RPP_ST_ACKNEG_BIT]   = s_d.ack_neg;
        s_d.status[`RPP_ST_DISABLED_BIT] = !s_d.enabled;
        s_d.status[`RPP_ST_RXAVAIL_BIT]  = s_d.rw != s_d.rr;
        if (!s_q.enabled && !serial_configure_request) begin
            s_d.tw = s_q.tr;
            s_d.txs = rpp_pkg::RPP_TX_IDLE;
            s_d.oe = 1'b0;
            s_d.txo = 1'b1;
        end
    end

    //--------------------------------------------------------------
    // Registers and buffer memories
    //--------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            s_q          <= '0;
            s_q.div      <= `RPP_DEF_DIV;
            s_q.start_ch <= `RPP_DEF_START;
            s_q.end_ch   <= `RPP_DEF_END;
            s_q.txo      <= 1'b1;
            s_q.rx_sync  <= 2'b11;
            s_q.status   <= 8'h20;
        end else begin
            s_q <= s_d;
        end
        if (tx_push)
            tx_mem[s_q.tw[PW-1:0]] <= f_out[7:0];
        if (rx_push)
            rx_mem[s_q.rw[PW-1:0]] <= s_q.rsh;
    end

    assign request_return_status = s_q.status;
    assign receive_data          = s_q.rdata;
    assign receive_valid         = s_q.rvalid;
    assign line_tx               = s_q.txo;
    assign line_tx_oe            = s_q.oe;

endmodule : rpp_port

`default_nettype wire

// ==== design/rpp_map.svh ====
// Constants of the point-to-point serial port
`ifndef RPP_MAP_SVH
`define RPP_MAP_SVH

`define RPP_CLK_HZ          40000000
`define RPP_MAX_BAUD        115200
`define RPP_MIN_DIV         ((`RPP_CLK_HZ + `RPP_MAX_BAUD - 1) / `RPP_MAX_BAUD)
`define RPP_DEF_DIV         16'h015B
`define RPP_BANK_BYTES      1024
`define RPP_BANKS           2
`define RPP_BUF_BYTES       (`RPP_BANK_BYTES * `RPP_BANKS)
`define RPP_FIFO_DEPTH      4
`define RPP_DEF_START       8'h02
`define RPP_DEF_END         8'h03
`define RPP_ACK_CHAR        8'h06
`define RPP_NAK_CHAR        8'h15
`define RPP_CHAR_NONE       8'hFF

`define RPP_ST_SENT_BIT     0
`define RPP_ST_FULL_BIT     1
`define RPP_ST_ACKWAIT_BIT  2
`define RPP_ST_ACKOK_BIT    3
`define RPP_ST_ACKNEG_BIT   4
`define RPP_ST_DISABLED_BIT 5
`define RPP_ST_RXAVAIL_BIT  6

`endif

// ==== design/rpp_pkg.sv ====
// Types of the point-to-point serial port
`default_nettype none
package rpp_pkg;

    typedef enum logic [2:0] {
        RPP_MODE_CHAR  = 3'h0,
        RPP_MODE_DELIM = 3'h1,
        RPP_MODE_PROC  = 3'h2,
        RPP_MODE_USS   = 3'h3,
        RPP_MODE_MBUS  = 3'h4
    } rpp_mode_t;

    typedef enum logic [2:0] {
        RPP_TX_IDLE  = 3'b000,
        RPP_TX_START = 3'b001,
        RPP_TX_DATA  = 3'b011,
        RPP_TX_END   = 3'b010,
        RPP_TX_BIT   = 3'b110
    } rpp_tx_t;

endpackage : rpp_pkg
`default_nettype wire

// ==== design/rpp_fifo.sv ====
// Small valid/ready FIFO in the outgoing byte path
`timescale 1ns/1ps
`default_nettype none

module rpp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    initial begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
            $error("rpp_fifo: DEPTH must be a power of two >= 2");
    end

    typedef struct packed {
        logic [AW:0] wr;
        logic [AW:0] rd;
    } rpp_fifo_st_t;

    rpp_fifo_st_t             s_q;
    rpp_fifo_st_t             s_d;
    logic         [WIDTH-1:0] mem [DEPTH];
    logic                     push;
    logic                     pop;

    assign in_ready  = (s_q.wr - s_q.rd) != (AW + 1)'(DEPTH);
    assign out_valid = s_q.wr != s_q.rd;
    assign out_data  = mem[s_q.rd[AW-1:0]];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        s_d = s_q;
        if (push)
            s_d.wr = s_q.wr + 1'b1;
        if (pop)
            s_d.rd = s_q.rd + 1'b1;
    end

    always_ff @(posedge clock) begin
        if (rst)
            s_q <= '0;
        else
            s_q <= s_d;
        if (push)
            mem[s_q.wr[AW-1:0]] <= in_data;
    end

endmodule : rpp_fifo

`default_nettype wire

// ==== bench/rpp_port_chk.sv ====
// Port checker for the point-to-point serial port, with its bind
`timescale 1ns/1ps
`default_nettype none
`include "rpp_map.svh"

module rpp_port_chk #(
    parameter int MIN_DIV = `RPP_MIN_DIV
) (
    input wire logic       clock,
    input wire logic       rst,
    input wire logic       serial_send_request,
    input wire logic       serial_receive_request,
    input wire logic [7:0] request_return_status,
    input wire logic       receive_valid,
    input wire logic       line_tx,
    input wire logic       line_tx_oe
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    // ------------------------------------------------------------------
    // Length of the current run of one line level
    // ------------------------------------------------------------------
    logic        prev_q;
    logic [15:0] run_q;
    always_ff @(posedge clock) begin
        if (rst) begin
            prev_q <= 1'b1;
            run_q  <= 16'hFFFF;
        end else begin
            prev_q <= line_tx;
            if (line_tx != prev_q) begin
                run_q <= 16'h0001;
            end else if (run_q != 16'hFFFF) begin
                run_q <= run_q + 16'h0001;
            end
        end
    end

    sequence s_open;
        $rose(line_tx_oe);
    endsequence
    sequence s_start_bit;
        ##[0:8] (!line_tx [*8]);
    endsequence

    property p_reset_quiet;
        @(posedge clock) disable iff (1'b0)
        rst |=> !line_tx_oe && line_tx && !receive_valid
                && request_return_status == 8'h20;
    endproperty
    property p_disabled_silent;
        request_return_status[`RPP_ST_DISABLED_BIT] && !line_tx_oe
            |=> !line_tx_oe;
    endproperty
    property p_idle_mark;
        !line_tx_oe |-> line_tx;
    endproperty
    property p_frame_start;
        s_open |-> s_start_bit;
    endproperty
    property p_bit_width;
        line_tx_oe && line_tx != prev_q |-> run_q >= MIN_DIV;
    endproperty
    property p_rx_answer;
        receive_valid |-> $past(serial_receive_request);
    endproperty
    property p_refuse_cause;
        $rose(request_return_status[`RPP_ST_FULL_BIT])
            |-> $past(serial_send_request);
    endproperty
    property p_sent_after;
        $fell(line_tx_oe) |-> ##[0:2] request_return_status[`RPP_ST_SENT_BIT];
    endproperty
    property p_ack_excl;
        request_return_status[`RPP_ST_ACKWAIT_BIT]
            |-> !request_return_status[`RPP_ST_ACKOK_BIT]
                && !request_return_status[`RPP_ST_ACKNEG_BIT];
    endproperty

    a_reset_quiet: assert property (p_reset_quiet)
        else $error("port not quiet after reset");
    a_disabled_silent: assert property (p_disabled_silent)
        else $error("line driven while disabled");
    a_idle_mark: assert property (p_idle_mark)
        else $error("released line not at mark");
    a_frame_start: assert property (p_frame_start)
        else $error("no start bit after line drive");
    a_bit_width: assert property (p_bit_width)
        else $error("bit shorter than minimum divider");
    a_rx_answer: assert property (p_rx_answer)
        else $error("receive valid without request");
    a_refuse_cause: assert property (p_refuse_cause)
        else $error("refused flag without send request");
    a_sent_after: assert property (p_sent_after)
        else $error("sent flag missing after drain");
    a_ack_excl: assert property (p_ack_excl)
        else $error("ack wait with ack result");
endmodule : rpp_port_chk

bind rpp_port rpp_port_chk #(.MIN_DIV(`RPP_MIN_DIV)) i_chk (
    .clock                  (clock),
    .rst                    (rst),
    .serial_send_request    (serial_send_request),
    .serial_receive_request (serial_receive_request),
    .request_return_status  (request_return_status),
    .receive_valid          (receive_valid),
    .line_tx                (line_tx),
    .line_tx_oe             (line_tx_oe)
);
`default_nettype wire

// ==== bench/rpp_far.sv ====
// Far station model: decodes frames on the wire, answers from a queue
`timescale 1ns/1ps
`default_nettype none

module rpp_far #(
    parameter int DIV = 348
) (
    input  wire logic clock,
    input  wire logic wire_lvl,
    input  wire logic line_tx_oe,
    output logic      far_tx,
    output logic      far_oe
);
    logic [7:0] got_q[$];
    logic [7:0] reply_q[$];
    logic [7:0] b;
    logic [9:0] fr;
    int         quiet;
    initial begin
        far_tx = 1'b1;
        far_oe = 1'b0;
        quiet  = 0;
    end
    // Decode 8N1, LSB first, sampled mid bit
    always begin
        @(posedge clock);
        if (line_tx_oe && !wire_lvl) begin
            repeat (DIV / 2 + DIV) @(posedge clock);
            for (int i = 0; i < 8; i++) begin
                b[i] = wire_lvl;
                repeat (DIV) @(posedge clock);
            end
            got_q.push_back(b);
        end
    end
    // Answer only once the port has released the line
    always begin
        @(posedge clock);
        quiet = line_tx_oe ? 0 : quiet + 1;
        if (quiet > 40 && reply_q.size() > 0) begin
            fr = {1'b1, reply_q.pop_front(), 1'b0};
            far_oe <= 1'b1;
            for (int i = 0; i < 10; i++) begin
                far_tx <= fr[i];
                repeat (DIV) @(posedge clock);
            end
            far_oe <= 1'b0;
        end
    end
endmodule : rpp_far
`default_nettype wire

// ==== bench/rpp_port_test.sv ====
// Self-checking bench for the point-to-point serial port
`timescale 1ns/1ps
`default_nettype none
`include "rpp_map.svh"

module rpp_port_test;
    localparam int DIV  = `RPP_MIN_DIV;
    localparam int BYTE = DIV * 10;
    logic       clock, rst, cfg_req, fn_set, snd_req, snd_last, rcv_req;
    logic       rx_v, tx, oe, far_tx, far_oe, wire_lvl, seen;
    logic [2:0] mode;
    logic [7:0] st_ch, en_ch, snd_d, status, rx_d;
    logic [15:0] div;
    int         n_errors, tests_run;

    // Shared half-duplex wire, biased to mark when released
    assign wire_lvl = (oe && far_oe) ? 1'bx : oe ? tx : far_oe ? far_tx : 1'b1;

    rpp_port #(.BUF_BYTES(8)) i_dut (
        .clock(clock), .rst(rst), .serial_configure_request(cfg_req),
        .interface_function_setting(fn_set), .cfg_mode(mode),
        .cfg_bit_div(div), .cfg_start_char(st_ch), .cfg_end_char(en_ch),
        .serial_send_request(snd_req), .send_data(snd_d),
        .send_last(snd_last), .request_return_status(status),
        .serial_receive_request(rcv_req), .receive_data(rx_d),
        .receive_valid(rx_v), .line_rx(wire_lvl), .line_tx(tx),
        .line_tx_oe(oe)
    );
    rpp_far #(.DIV(DIV)) i_far (
        .clock(clock), .wire_lvl(wire_lvl), .line_tx_oe(oe),
        .far_tx(far_tx), .far_oe(far_oe)
    );

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    task automatic tick(input int n = 1);
        repeat (n) @(posedge clock);
        #2;
    endtask : tick

    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] seen_v);
        tests_run++;
        if (seen_v !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen_v);
        end
    endtask : chk

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : print_verdict

    task automatic cfg(input logic en, input logic [2:0] m);
        fn_set  = en;
        mode    = m;
        cfg_req = 1'b1;
        tick();
        cfg_req = 1'b0;
        tick();
    endtask : cfg

    task automatic burst(input logic [7:0] b, input int n, input logic last,
                         output logic full);
        full    = 1'b0;
        snd_req = 1'b1;
        for (int i = 0; i < n; i++) begin
            snd_d    = b + 8'(i);
            snd_last = last && (i == n - 1);
            tick();
            full = full | status[`RPP_ST_FULL_BIT];
        end
        snd_req = 1'b0;
        tick();
    endtask : burst

    task automatic drain(input int nb);
        int k;
        k = 0;
        while (oe !== 1'b1 && k < 50) begin
            tick();
            k++;
        end
        while (oe === 1'b1 && k < (nb + 1) * BYTE) begin
            tick();
            k++;
        end
        chk("tx enable", 8'h00, {7'h0, oe});
        tick(8);
    endtask : drain

    task automatic got(input logic [7:0] exp);
        logic [7:0] g;
        g = 8'hXX;
        if (i_far.got_q.size() > 0) begin
            g = i_far.got_q.pop_front();
        end
        chk("line byte", exp, g);
    endtask : got

    task automatic rcv(input logic [7:0] exp);
        rcv_req = 1'b1;
        tick();
        rcv_req = 1'b0;
        chk("rx valid", 8'h01, {7'h0, rx_v});
        chk("rx data", exp, rx_d);
    endtask : rcv

    task automatic t_reset();
        chk("status", 8'h20, status);
        burst(8'h41, 1, 1'b1, seen);
        tick(20);
        chk("tx enable", 8'h00, {7'h0, oe});
    endtask : t_reset

    task automatic t_off();
        cfg(1'b0, rpp_pkg::RPP_MODE_CHAR);
        burst(8'h42, 1, 1'b1, seen);
        tick(20);
        chk("tx enable", 8'h00, {7'h0, oe});
        chk("disabled", 8'h20, status & 8'h20);
    endtask : t_off

    task automatic t_char();
        cfg(1'b1, rpp_pkg::RPP_MODE_CHAR);
        burst(8'hA5, 3, 1'b1, seen);
        drain(3);
        got(8'hA5);
        got(8'hA6);
        got(8'hA7);
        chk("ack", 8'h01, status & 8'h1D);
        chk("rx avail", 8'h00, status & 8'h40);
    endtask : t_char

    task automatic t_delim();
        cfg(1'b1, rpp_pkg::RPP_MODE_DELIM);
        burst(8'h31, 2, 1'b1, seen);
        drain(4);
        got(`RPP_DEF_START);
        got(8'h31);
        got(8'h32);
        got(`RPP_DEF_END);
        // No start character: only the end delimiter is added
        st_ch = `RPP_CHAR_NONE;
        cfg(1'b1, rpp_pkg::RPP_MODE_DELIM);
        burst(8'h33, 1, 1'b1, seen);
        drain(2);
        got(8'h33);
        got(`RPP_DEF_END);
        st_ch = `RPP_DEF_START;
    endtask : t_delim

    task automatic t_full();
        cfg(1'b1, rpp_pkg::RPP_MODE_CHAR);
        burst(8'h00, 16, 1'b0, seen);
        chk("refused", 8'h01, {7'h0, seen});
        tick(2 * BYTE + DIV);
        got(8'h00);
        got(8'h01);
        rst = 1'b1;
        tick(2);
        rst = 1'b0;
        tick(BYTE);
        i_far.got_q.delete();
        chk("status", 8'h20, status);
    endtask : t_full

    task automatic t_ack();
        logic [2:0] m;
        logic [7:0] a;
        for (int k = 0; k < 3; k++) begin
            m = 3'(int'(rpp_pkg::RPP_MODE_PROC) + k);
            a = (k == 1) ? `RPP_NAK_CHAR : `RPP_ACK_CHAR;
            cfg(1'b1, m);
            burst(8'h50, 1, 1'b1, seen);
            drain(1);
            chk("ack wait", 8'h05, status & 8'h1D);
            i_far.got_q.delete();
            i_far.reply_q.push_back(a);
            tick(BYTE + 100);
            chk("ack state", (k == 1) ? 8'h10 : 8'h08, status & 8'h1C);
            rcv(a);
        end
    endtask : t_ack

    initial begin
        repeat (26 * BYTE) @(posedge clock);
        n_errors++;
        print_verdict();
    end

    initial begin
        rst      = 1'b1;
        cfg_req  = 1'b0;
        fn_set   = 1'b0;
        mode     = 3'h0;
        div      = 16'h0010;
        st_ch    = `RPP_DEF_START;
        en_ch    = `RPP_DEF_END;
        snd_req  = 1'b0;
        snd_d    = 8'h00;
        snd_last = 1'b0;
        rcv_req  = 1'b0;
        tick(2);
        rst = 1'b0;
        tick();
        t_reset();
        t_off();
        t_char();
        t_delim();
        t_full();
        t_ack();
        print_verdict();
    end
endmodule : rpp_port_test
`default_nettype wire
